// *** hdl/tlb_lookup_page_history.sv ***
// Instruction and data translation lookup with page history flag recording
// What this block does
// - Several matching history scenarios: only the highest-priority outcome applies.
// - External-control and cache ops count as loads or stores as they translate.
// - No-execute violation sets no flag; page protection violation sets referenced only.
// - Out-of-order fetches, loads, stores and instruction-block invalidates set no flag.
// - In-order fetch, loads, touch, store-back and flush set referenced only.
// - Stores, external stores, block zero and data-block invalidate set both flags.
// - Zero-length string store and failed conditional store still set both flags.
// - Setting the changed flag always sets the referenced flag too.
// - Both units look up in one clock; one exception reported at a time.
// - Instruction-buffer miss reported only once the pipeline is empty.
// - Data-buffer miss reported only when its instruction is ready to retire.
// - Entry holds tag word, data word and five extra page-index bits.
// - Top four address bits pick one of sixteen segment registers.
// - Five address bits index a two-way set; valid and tags are compared.
// - On hit check key and changed flag, then forward page number and attributes.
// - Reset disables translation but leaves entry valid bits untouched.
// - Store hitting an entry with changed clear raises data store miss.
`include "tlb_lookup_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tlb_lookup_page_history
	import tlb_lookup_pkg::*;
#(
	parameter logic [3:0] REAL_MODE_ATTR = 4'h0
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	output logic             irq,
	input  wire instr_req_t  i_req,
	input  wire data_req_t   d_req,
	input  wire logic        pipeline_empty,
	input  wire logic        data_retire_ready,
	output xlate_rsp_t       i_rsp,
	output xlate_rsp_t       d_rsp,
	output history_t         i_hist,
	output history_t         d_hist,
	output logic             exc_valid,
	output exc_code_t        exc_code
);
	// Entry arrays carry no reset: valid bits survive reset by design
	tlb_tag_t  i_tag [`TLB_SETS][2];
	tlb_data_t i_dat [`TLB_SETS][2];
	tlb_tag_t  d_tag [`TLB_SETS][2];
	tlb_data_t d_dat [`TLB_SETS][2];
	seg_reg_t  seg   [`TLB_SEGS];

	logic                 ien;
	logic                 den;
	logic [`TLB_ST_W-1:0] status;
	logic [`TLB_ST_W-1:0] mask;
	logic [31:0]          load_tag;
	logic [31:0]          load_data;
	exc_code_t            i_pend;
	exc_code_t            d_pend;

	logic apb_wr;
	logic apb_rd;
	logic apb_setup_rd;
	logic mapped;
	logic seg_sel;
	assign seg_sel = paddr >= `TLB_OFS_SEG_BASE && paddr <= `TLB_OFS_SEG_LAST && paddr[1:0] == 2'h0;
	assign mapped  = seg_sel || paddr == `TLB_OFS_CTRL || paddr == `TLB_OFS_STATUS ||
		paddr == `TLB_OFS_MASK || paddr == `TLB_OFS_LOAD_TAG ||
		paddr == `TLB_OFS_LOAD_DATA || paddr == `TLB_OFS_LOAD_CMD;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign apb_wr       = psel && penable && pwrite && mapped;
	assign apb_rd       = psel && penable && !pwrite && mapped;
	assign apb_setup_rd = psel && !penable && !pwrite;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup_rd) begin
			prdata <= 32'h0000_0000;
			if (seg_sel)
				prdata <= {1'b0, seg[paddr[5:2]].key_super, seg[paddr[5:2]].key_user,
					seg[paddr[5:2]].no_execute, 4'h0, seg[paddr[5:2]].virtual_segment_id};
			else if (paddr == `TLB_OFS_CTRL)
				prdata <= {30'h0, den, ien};
			else if (paddr == `TLB_OFS_STATUS)
				prdata <= {28'h0, status};
			else if (paddr == `TLB_OFS_MASK)
				prdata <= {28'h0, mask};
			else if (paddr == `TLB_OFS_LOAD_TAG)
				prdata <= load_tag;
			else if (paddr == `TLB_OFS_LOAD_DATA)
				prdata <= load_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ien  <= 1'b0;
			den  <= 1'b0;
			mask <= `TLB_MASK_RESET;
		end else if (apb_wr && paddr == `TLB_OFS_CTRL) begin
			ien <= pwdata[`TLB_CTRL_IEN];
			den <= pwdata[`TLB_CTRL_DEN];
		end else if (apb_wr && paddr == `TLB_OFS_MASK) begin
			mask <= pwdata[`TLB_ST_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			load_tag  <= 32'h0000_0000;
			load_data <= 32'h0000_0000;
		end else if (apb_wr && paddr == `TLB_OFS_LOAD_TAG) begin
			load_tag <= pwdata;
		end else if (apb_wr && paddr == `TLB_OFS_LOAD_DATA) begin
			load_data <= pwdata;
		end
	end

	// Segments have no valid bit; software must set them before use
	always_ff @(posedge clk) begin
		if (apb_wr && seg_sel)
			seg[paddr[5:2]] <= '{pwdata[23:0], pwdata[`TLB_SEG_KS], pwdata[`TLB_SEG_KP],
				pwdata[`TLB_SEG_NOEXEC]};
	end

	// Entry load and set invalidate; invalidate clears both ways of both units
	logic      cmd_wr;
	logic      cmd_inval;
	logic      cmd_unit;
	logic      cmd_way;
	logic [4:0] cmd_idx;
	tlb_tag_t  new_tag;
	tlb_data_t new_dat;
	assign cmd_wr    = apb_wr && paddr == `TLB_OFS_LOAD_CMD;
	assign cmd_inval = pwdata[`TLB_CMD_INVAL];
	assign cmd_unit  = pwdata[`TLB_CMD_UNIT];
	assign cmd_way   = pwdata[`TLB_CMD_WAY];
	assign cmd_idx   = pwdata[`TLB_CMD_IDX_LO +: 5];
	assign new_tag   = '{1'b1, load_tag[23:0], load_tag[`TLB_TAG_API_LO +: 6],
		pwdata[`TLB_CMD_EXTRA_LO +: 5]};
	assign new_dat   = '{load_data[31:12], load_data[`TLB_DATA_C],
		load_data[`TLB_DATA_STORAGE_ATTR_BITS_LO +: 4], load_data[1:0]};

	always_ff @(posedge clk) begin
		if (cmd_wr && cmd_inval) begin
			i_tag[cmd_idx][0].valid <= 1'b0;
			i_tag[cmd_idx][1].valid <= 1'b0;
		end else if (cmd_wr && !cmd_unit) begin
			i_tag[cmd_idx][cmd_way] <= new_tag;
			i_dat[cmd_idx][cmd_way] <= new_dat;
		end
	end

	always_ff @(posedge clk) begin
		if (cmd_wr && cmd_inval) begin
			d_tag[cmd_idx][0].valid <= 1'b0;
			d_tag[cmd_idx][1].valid <= 1'b0;
		end else if (cmd_wr && cmd_unit) begin
			d_tag[cmd_idx][cmd_way] <= new_tag;
			d_dat[cmd_idx][cmd_way] <= new_dat;
		end
	end

	function automatic logic tag_match(tlb_tag_t t, seg_reg_t s, logic [31:0] ea);
		tag_match = t.valid && t.virtual_segment_id == s.virtual_segment_id &&
			t.abbrev_page_index == ea[27:22] && t.extra_index == ea[21:17];
	endfunction

	function automatic logic may_read(logic key, logic [1:0] pp);
		may_read = !(key && pp == 2'b00);
	endfunction

	function automatic logic may_write(logic key, logic [1:0] pp);
		may_write = key ? (pp == 2'b10) : (pp != 2'b11);
	endfunction

	// Both units look up in the same cycle through separate read ports
	seg_reg_t  i_seg;
	seg_reg_t  d_seg;
	logic [1:0] i_way_hit;
	logic [1:0] d_way_hit;
	tlb_data_t i_ent;
	tlb_data_t d_ent;
	assign i_seg = seg[i_req.eff_addr[31:28]];
	assign d_seg = seg[d_req.eff_addr[31:28]];
	genvar w;
	generate
		for (w = 0; w < 2; w++) begin : g_way
			assign i_way_hit[w] = tag_match(i_tag[i_req.eff_addr[16:12]][w], i_seg, i_req.eff_addr);
			assign d_way_hit[w] = tag_match(d_tag[d_req.eff_addr[16:12]][w], d_seg, d_req.eff_addr);
		end
	endgenerate
	assign i_ent = i_way_hit[0] ? i_dat[i_req.eff_addr[16:12]][0] : i_dat[i_req.eff_addr[16:12]][1];
	assign d_ent = d_way_hit[0] ? d_dat[d_req.eff_addr[16:12]][0] : d_dat[d_req.eff_addr[16:12]][1];

	logic i_look;
	logic i_hit;
	logic i_noexec;
	logic i_prot;
	assign i_look   = i_req.valid && ien;
	assign i_hit    = |i_way_hit;
	assign i_noexec = i_seg.no_execute;
	assign i_prot   = i_hit && !i_noexec &&
		!may_read(i_req.supervisor ? i_seg.key_super : i_seg.key_user, i_ent.page_access_key);

	// Fetch history, checked in priority order
	history_t next_i_hist;
	always_comb begin
		next_i_hist = '{1'b0, 1'b0};
		if (!i_look || i_noexec)
			next_i_hist = '{1'b0, 1'b0};
		else if (i_prot)
			next_i_hist = '{1'b1, 1'b0};
		else if (i_req.out_of_order)
			next_i_hist = '{1'b0, 1'b0};
		else if (i_hit)
			next_i_hist = '{1'b1, 1'b0};
	end

	logic d_look;
	logic d_hit;
	logic d_store;
	logic d_key;
	logic d_prot;
	logic d_cmiss;
	assign d_look  = d_req.valid && den;
	assign d_hit   = |d_way_hit;
	assign d_key   = d_req.supervisor ? d_seg.key_super : d_seg.key_user;
	// Cache ops are classed by how they translate, not by what they do
	assign d_store = d_req.op inside {OP_STORE, OP_EXT_STORE, OP_ZERO_BLOCK, OP_DBLK_INV,
		OP_STR_STORE_ZERO, OP_COND_STORE_NORES};
	assign d_prot  = d_hit && (d_store ? !may_write(d_key, d_ent.page_access_key)
		: !may_read(d_key, d_ent.page_access_key));
	assign d_cmiss = d_look && d_hit && d_store && !d_prot && !d_ent.changed;

	history_t next_d_hist;
	always_comb begin
		next_d_hist = '{1'b0, 1'b0};
		if (!d_look || !d_hit)
			next_d_hist = '{1'b0, 1'b0};
		else if (d_prot)
			next_d_hist = '{1'b1, 1'b0};
		else if (d_req.out_of_order || d_req.op == OP_IBLK_INV)
			next_d_hist = '{1'b0, 1'b0};
		else if (d_store)
			next_d_hist = '{1'b1, 1'b1};
		else
			next_d_hist = '{1'b1, 1'b0};
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			i_hist <= '{1'b0, 1'b0};
			d_hist <= '{1'b0, 1'b0};
		end else begin
			i_hist <= next_i_hist;
			d_hist <= next_d_hist;
		end
	end

	// Real page number goes out only when no exception is raised
	always_ff @(posedge clk) begin
		if (!resetn) begin
			i_rsp <= '0;
		end else if (!i_req.valid) begin
			i_rsp <= '0;
		end else if (!ien) begin
			i_rsp <= '{1'b1, 1'b1, 1'b0, i_req.eff_addr, REAL_MODE_ATTR};
		end else if (i_hit && !i_noexec && !i_prot) begin
			i_rsp <= '{1'b1, 1'b1, 1'b0, {i_ent.real_page_number, i_req.eff_addr[11:0]},
				i_ent.storage_attr_bits};
		end else begin
			i_rsp <= '{1'b1, 1'b0, i_noexec || i_prot, 32'h0000_0000, 4'h0};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			d_rsp <= '0;
		end else if (!d_req.valid) begin
			d_rsp <= '0;
		end else if (!den) begin
			d_rsp <= '{1'b1, 1'b1, 1'b0, d_req.eff_addr, REAL_MODE_ATTR};
		end else if (d_hit && !d_prot && !d_cmiss) begin
			d_rsp <= '{1'b1, 1'b1, 1'b0, {d_ent.real_page_number, d_req.eff_addr[11:0]},
				d_ent.storage_attr_bits};
		end else begin
			d_rsp <= '{1'b1, 1'b0, d_prot, 32'h0000_0000, 4'h0};
		end
	end

	// Exceptions wait in a holding slot; a second one behind it is dropped
	exc_code_t next_i_exc;
	exc_code_t next_d_exc;
	logic      take_d;
	logic      take_i;
	assign next_i_exc = !i_look ? EXC_NONE : (i_noexec || i_prot) ? EXC_INSTR_PROT
		: !i_hit ? EXC_INSTR_MISS : EXC_NONE;
	assign next_d_exc = !d_look ? EXC_NONE : d_prot ? EXC_DATA_PROT
		: !d_hit ? (d_store ? EXC_DATA_STORE_MISS : EXC_DATA_LOAD_MISS)
		: d_cmiss ? EXC_DATA_STORE_MISS : EXC_NONE;
	assign take_d = d_pend != EXC_NONE && data_retire_ready;
	assign take_i = i_pend != EXC_NONE && pipeline_empty && !take_d;

	always_ff @(posedge clk) begin
		if (!resetn)
			i_pend <= EXC_NONE;
		else if (take_i)
			i_pend <= EXC_NONE;
		else if (i_pend == EXC_NONE)
			i_pend <= next_i_exc;
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			d_pend <= EXC_NONE;
		else if (take_d)
			d_pend <= EXC_NONE;
		else if (d_pend == EXC_NONE)
			d_pend <= next_d_exc;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			exc_valid <= 1'b0;
			exc_code  <= EXC_NONE;
		end else begin
			exc_valid <= take_d || take_i;
			exc_code  <= take_d ? d_pend : take_i ? i_pend : EXC_NONE;
		end
	end

	// Status bits set on report; a read clears only what it showed, so an
	// event landing between setup and access is not lost; a same-cycle event wins
	logic [`TLB_ST_W-1:0] ev;
	logic                 st_rd;
	exc_code_t            taken;
	assign taken = take_d ? d_pend : take_i ? i_pend : EXC_NONE;
	assign ev[`TLB_ST_IMISS]  = taken == EXC_INSTR_MISS;
	assign ev[`TLB_ST_DMISS]  = taken == EXC_DATA_LOAD_MISS;
	assign ev[`TLB_ST_DSTORE] = taken == EXC_DATA_STORE_MISS;
	assign ev[`TLB_ST_PROT]   = taken == EXC_INSTR_PROT || taken == EXC_DATA_PROT;
	assign st_rd = apb_rd && paddr == `TLB_OFS_STATUS;

	always_ff @(posedge clk) begin
		if (!resetn)
			status <= `TLB_STATUS_RESET;
		else
			status <= (st_rd ? (status & ~prdata[`TLB_ST_W-1:0]) : status) | ev;
	end

	assign irq = |(status & mask);

	AST_NOEXEC_NO_FLAGS: assert property (@(posedge clk) disable iff (!resetn)
		(i_look && i_noexec) |=> !i_hist.set_referenced && !i_hist.set_changed)
		else $error("flag set on no-execute violation");
	AST_PROT_REF_ONLY: assert property (@(posedge clk) disable iff (!resetn)
		(d_look && d_prot) |=> d_hist.set_referenced && !d_hist.set_changed)
		else $error("protection violation flags wrong");
	AST_CHG_HAS_REF: assert property (@(posedge clk) disable iff (!resetn)
		d_hist.set_changed |-> d_hist.set_referenced && d_rsp.done)
		else $error("changed without referenced");
	AST_OOO_NO_FLAGS: assert property (@(posedge clk) disable iff (!resetn)
		(d_look && d_req.out_of_order && !d_prot) |=> !d_hist.set_referenced
		&& !d_hist.set_changed)
		else $error("out-of-order access set a flag");
	AST_STORE_CMISS: assert property (@(posedge clk) disable iff (!resetn)
		d_cmiss |=> d_rsp.done && !d_rsp.hit && d_pend != EXC_NONE || exc_valid)
		else $error("store to clean page forwarded");
	AST_IMISS_WAITS: assert property (@(posedge clk) disable iff (!resetn)
		(i_pend != EXC_NONE && !pipeline_empty) |=> !(exc_valid && exc_code == $past(i_pend)
		&& $past(d_pend) == EXC_NONE))
		else $error("instruction exception reported early");
	AST_DMISS_WAITS: assert property (@(posedge clk) disable iff (!resetn)
		(d_pend != EXC_NONE && !data_retire_ready) |=> exc_code != $past(d_pend))
		else $error("data exception reported before retire");
	AST_ONE_AT_A_TIME: assert property (@(posedge clk) disable iff (!resetn)
		(take_d && i_pend != EXC_NONE) |=> exc_code == $past(d_pend) && i_pend != EXC_NONE)
		else $error("two exceptions reported together");
	AST_MISS_SIGNALLED: assert property (@(posedge clk) disable iff (!resetn)
		(i_look && i_way_hit == 2'b00) |=> i_rsp.done && !i_rsp.hit)
		else $error("miss not signalled");
	AST_RESET_XLATE_OFF: assert property (@(posedge clk)
		$rose(resetn) |-> !ien && !den)
		else $error("translation enabled after reset");
endmodule
`default_nettype wire

// *** hdl/tlb_lookup_params.svh ***
// Register offsets, field positions and reset values of the translation lookup block
`ifndef TLB_LOOKUP_PARAMS_SVH
`define TLB_LOOKUP_PARAMS_SVH

`define TLB_OFS_CTRL      12'h000
`define TLB_OFS_STATUS    12'h004
`define TLB_OFS_MASK      12'h008
`define TLB_OFS_LOAD_TAG  12'h00C
`define TLB_OFS_LOAD_DATA 12'h010
`define TLB_OFS_LOAD_CMD  12'h014
`define TLB_OFS_SEG_BASE  12'h040
`define TLB_OFS_SEG_LAST  12'h07C

`define TLB_CTRL_IEN      0
`define TLB_CTRL_DEN      1
`define TLB_ST_IMISS      0
`define TLB_ST_DMISS      1
`define TLB_ST_DSTORE     2
`define TLB_ST_PROT       3
`define TLB_ST_W          4
`define TLB_STATUS_RESET  4'h0
`define TLB_MASK_RESET    4'h0

`define TLB_SEG_KS        30
`define TLB_SEG_KP        29
`define TLB_SEG_NOEXEC    28

`define TLB_CMD_UNIT      0
`define TLB_CMD_WAY       1
`define TLB_CMD_IDX_LO    2
`define TLB_CMD_INVAL     7
`define TLB_CMD_EXTRA_LO  8
`define TLB_DATA_C        7
`define TLB_DATA_STORAGE_ATTR_BITS_LO  3
`define TLB_TAG_API_LO    24

`define TLB_SETS          32
`define TLB_SEGS          16
`endif

// *** hdl/tlb_lookup_pkg.sv ***
// Types shared by the translation lookup block and its users
package tlb_lookup_pkg;
	typedef enum logic [3:0] {
		OP_LOAD, OP_EXT_LOAD, OP_STR_LOAD_ZERO, OP_TOUCH, OP_STORE_BACK, OP_FLUSH,
		OP_STORE, OP_EXT_STORE, OP_ZERO_BLOCK, OP_DBLK_INV, OP_STR_STORE_ZERO,
		OP_COND_STORE_NORES, OP_IBLK_INV
	} data_op_t;
	typedef enum logic [2:0] {
		EXC_NONE, EXC_INSTR_MISS, EXC_INSTR_PROT, EXC_DATA_LOAD_MISS,
		EXC_DATA_STORE_MISS, EXC_DATA_PROT
	} exc_code_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] eff_addr;
		logic        out_of_order;
		logic        supervisor;
	} instr_req_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] eff_addr;
		data_op_t    op;
		logic        out_of_order;
		logic        supervisor;
	} data_req_t;
	typedef struct packed {
		logic        done;
		logic        hit;
		logic        fault;
		logic [31:0] real_addr;
		logic [3:0]  storage_attr_bits;
	} xlate_rsp_t;
	typedef struct packed {
		logic set_referenced;
		logic set_changed;
	} history_t;
	typedef struct packed {
		logic        valid;
		logic [23:0] virtual_segment_id;
		logic [5:0]  abbrev_page_index;
		logic [4:0]  extra_index;
	} tlb_tag_t;
	typedef struct packed {
		logic [19:0] real_page_number;
		logic        changed;
		logic [3:0]  storage_attr_bits;
		logic [1:0]  page_access_key;
	} tlb_data_t;
	typedef struct packed {
		logic [23:0] virtual_segment_id;
		logic        key_super;
		logic        key_user;
		logic        no_execute;
	} seg_reg_t;
endpackage

// *** tb/pipe_model.sv ***
// Fetch and load/store pipeline stand-in that drives the lookup requests
`timescale 1ns/10ps
`default_nettype none
module pipe_model
	import tlb_lookup_pkg::*;
(
	input  wire logic	clk,
	output var instr_req_t	i_req,
	output var data_req_t	d_req,
	output var logic	pipeline_empty,
	output var logic	data_retire_ready
);
	initial begin
		i_req = '0;
		d_req = '0;
		pipeline_empty = 1'b0;
		data_retire_ready = 1'b0;
	end

	// One-cycle request; released address lines flip so a stale value never looks valid
	task automatic issue(input instr_req_t i, input data_req_t d);
		@(posedge clk);
		i_req <= i;
		d_req <= d;
		@(posedge clk);
		i_req <= '{1'b0, ~i.eff_addr, i.out_of_order, i.supervisor};
		d_req <= '{1'b0, ~d.eff_addr, d.op, d.out_of_order, d.supervisor};
	endtask

	task automatic levels(input logic empty, input logic retire);
		@(posedge clk);
		pipeline_empty <= empty;
		data_retire_ready <= retire;
	endtask
endmodule
`default_nettype wire

// *** tb/test_tlb_lookup_page_history.sv ***
// Self-checking bench for the translation lookup and page history block
`include "tlb_lookup_params.svh"
`timescale 1ns/10ps
`default_nettype none
module test_tlb_lookup_page_history
	import tlb_lookup_pkg::*;
;
	localparam logic [31:0] EA_HIT = 32'h11464123;
	localparam logic [31:0] EA_CLEAN = 32'h114E4123;
	localparam logic [31:0] EA_RO = 32'h11465123;
	localparam logic [31:0] EA_MISS = 32'h11469123;
	localparam logic [3:0] REAL_ATTR = 4'hA;
	typedef struct packed {
		data_op_t	op;
		logic [31:0]	ea;
		logic		ooo;
		logic [1:0]	mode;
		history_t	hist;
	} row_t;
	logic		clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
	logic		pipeline_empty, data_retire_ready, exc_valid, rerr;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rdata;
	instr_req_t	i_req;
	data_req_t	d_req;
	xlate_rsp_t	i_rsp, d_rsp;
	history_t	i_hist, d_hist;
	exc_code_t	exc_code;
	int		miscompares = 0;
	int		cmp_count = 0;
	// Mode 1: hit with forwarded page, mode 2: no hit, mode 3: protection fault, mode 0: not judged
	row_t rows [19] = '{
		'{OP_LOAD, EA_HIT, 1'b0, 2'd1, 2'b10}, '{OP_EXT_LOAD, EA_HIT, 1'b0, 2'd1, 2'b10},
		'{OP_STR_LOAD_ZERO, EA_HIT, 1'b0, 2'd1, 2'b10}, '{OP_TOUCH, EA_HIT, 1'b0, 2'd1, 2'b10},
		'{OP_STORE_BACK, EA_HIT, 1'b0, 2'd1, 2'b10}, '{OP_FLUSH, EA_HIT, 1'b0, 2'd1, 2'b10},
		'{OP_STORE, EA_HIT, 1'b0, 2'd1, 2'b11}, '{OP_EXT_STORE, EA_HIT, 1'b0, 2'd1, 2'b11},
		'{OP_ZERO_BLOCK, EA_HIT, 1'b0, 2'd1, 2'b11}, '{OP_DBLK_INV, EA_HIT, 1'b0, 2'd1, 2'b11},
		'{OP_STR_STORE_ZERO, EA_HIT, 1'b0, 2'd1, 2'b11},
		'{OP_COND_STORE_NORES, EA_HIT, 1'b0, 2'd1, 2'b11},
		'{OP_IBLK_INV, EA_HIT, 1'b0, 2'd1, 2'b00}, '{OP_LOAD, EA_HIT, 1'b1, 2'd0, 2'b00},
		'{OP_STORE, EA_HIT, 1'b1, 2'd0, 2'b00}, '{OP_STORE, EA_CLEAN, 1'b0, 2'd2, 2'b11},
		'{OP_STORE, EA_RO, 1'b1, 2'd3, 2'b10}, '{OP_COND_STORE_NORES, EA_RO, 1'b0, 2'd3, 2'b10},
		'{OP_LOAD, EA_MISS, 1'b0, 2'd2, 2'b00}
	};

	pipe_model u_pipe (.clk(clk), .i_req(i_req), .d_req(d_req), .pipeline_empty(pipeline_empty),
		.data_retire_ready(data_retire_ready));
	tlb_lookup_page_history #(.REAL_MODE_ATTR(REAL_ATTR)) u_dut (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .irq(irq), .i_req(i_req),
		.d_req(d_req), .pipeline_empty(pipeline_empty), .data_retire_ready(data_retire_ready),
		.i_rsp(i_rsp), .d_rsp(d_rsp), .i_hist(i_hist), .d_hist(d_hist),
		.exc_valid(exc_valid), .exc_code(exc_code));

	task automatic give_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic load_entry(input logic [31:0] data, input logic [31:0] cmd);
		apb(1'b1, `TLB_OFS_LOAD_TAG, 32'h05000ABC);
		apb(1'b1, `TLB_OFS_LOAD_DATA, data);
		apb(1'b1, `TLB_OFS_LOAD_CMD, cmd);
	endtask

	// Only one report may appear; the cycle after must be quiet again
	task automatic wait_exc(input exc_code_t code);
		int n = 0;
		@(negedge clk);
		while (exc_valid !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		chk(exc_code, code);
		@(negedge clk);
		chk(exc_valid, 0);
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Setup plus checks take well under a thousand cycles
	initial begin
		#500000;
		miscompares++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk({exc_valid, irq, d_rsp.done}, 0);
		apb(1'b0, `TLB_OFS_CTRL, 32'h0);
		chk(rdata, 0);
		for (int n = 0; n < `TLB_SETS; n++)
			apb(1'b1, `TLB_OFS_LOAD_CMD, 32'(32'h80 | (n << 2)));
		for (int n = 0; n < `TLB_SEGS; n++)
			apb(1'b1, `TLB_OFS_SEG_BASE + 12'(4 * n), (n == 2) ? 32'h10000ABC : 32'h00000ABC);
		load_entry(32'h123450AA, 32'h310);
		load_entry(32'h123450AA, 32'h311);
		load_entry(32'h1234602A, 32'h713);
		load_entry(32'h123470AB, 32'h315);
		apb(1'b1, `TLB_OFS_CTRL, 32'h3);
		foreach (rows[k]) begin
			u_pipe.issue('0, '{1'b1, rows[k].ea, rows[k].op, rows[k].ooo, 1'b1});
			@(negedge clk);
			chk(d_rsp.done, 1);
			chk(d_hist, rows[k].hist);
			if (rows[k].mode == 2'd1) begin
				chk(d_rsp.hit, 1);
				chk(d_rsp.real_addr, {20'h12345, rows[k].ea[11:0]});
				chk(d_rsp.storage_attr_bits, 4'h5);
			end
			if (rows[k].mode == 2'd2) begin
				chk(d_rsp.hit, 0);
				chk(d_rsp.fault, 0);
			end
			if (rows[k].mode == 2'd3)
				chk(d_rsp.fault, 1);
			chk(exc_valid, 0);
		end
		u_pipe.levels(1'b0, 1'b1);
		wait_exc(EXC_DATA_STORE_MISS);
		u_pipe.levels(1'b0, 1'b0);
		@(negedge clk);
		chk(irq, 0);
		apb(1'b1, `TLB_OFS_MASK, 32'h4);
		@(negedge clk);
		chk(irq, 1);
		apb(1'b0, `TLB_OFS_STATUS, 32'h0);
		chk(rdata & 32'h4, 32'h4);
		@(negedge clk);
		chk(irq, 0);
		apb(1'b0, 12'h020, 32'h0);
		chk(rerr, 1);
		u_pipe.issue('{1'b1, EA_MISS, 1'b0, 1'b1}, '0);
		@(negedge clk);
		chk(i_rsp.hit, 0);
		repeat (3) @(negedge clk);
		chk(exc_valid, 0);
		u_pipe.levels(1'b1, 1'b0);
		wait_exc(EXC_INSTR_MISS);
		u_pipe.levels(1'b0, 1'b0);
		u_pipe.issue('{1'b1, EA_HIT, 1'b0, 1'b1}, '{1'b1, EA_HIT, OP_STORE, 1'b0, 1'b1});
		@(negedge clk);
		chk(i_rsp.hit, 1);
		chk(i_rsp.real_addr, {20'h12345, EA_HIT[11:0]});
		chk(i_rsp.storage_attr_bits, 4'h5);
		chk({i_hist, d_hist}, 4'b1011);
		u_pipe.issue('{1'b1, EA_HIT, 1'b1, 1'b1}, '0);
		@(negedge clk);
		chk(i_hist, 0);
		u_pipe.issue('{1'b1, 32'h21464123, 1'b0, 1'b1}, '0);
		@(negedge clk);
		chk(i_hist, 0);
		chk(i_rsp.fault, 1);
		// Both slots full: data report first, the instruction one a cycle later
		u_pipe.issue('0, '{1'b1, EA_MISS, OP_LOAD, 1'b0, 1'b1});
		u_pipe.levels(1'b1, 1'b1);
		repeat (2) @(negedge clk);
		chk(exc_code, EXC_DATA_LOAD_MISS);
		@(negedge clk);
		chk(exc_code, EXC_INSTR_PROT);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		u_pipe.issue('0, '{1'b1, EA_HIT, OP_STORE, 1'b0, 1'b1});
		@(negedge clk);
		chk(d_rsp.real_addr, EA_HIT);
		chk(d_rsp.storage_attr_bits, REAL_ATTR);
		chk(d_hist, 0);
		apb(1'b1, `TLB_OFS_CTRL, 32'h3);
		u_pipe.issue('0, '{1'b1, EA_HIT, OP_LOAD, 1'b0, 1'b1});
		@(negedge clk);
		chk(d_rsp.hit, 1);
		chk(d_rsp.real_addr, {20'h12345, EA_HIT[11:0]});
		give_verdict();
	end
endmodule
`default_nettype wire
